// ===== inc/mpwc_pkg.sv
package mpwc_pkg;
  localparam int WORD_W    = 70;
  localparam int SEL_BIT   = 0;
  localparam int BANK_BIT  = 1;
  localparam int BANK1_OFS = 33;
  localparam int PLEV_LSB  = 2;
  localparam int PLEV_W    = 22;
  localparam int FLED_LSB  = 24;
  localparam int FCAL_LSB  = 27;
  localparam int FMON_LSB  = 29;
  localparam int CREEP_LSB = 31;
  localparam int GAIN_LSB  = 33;
  localparam logic [1:0]  DEF_GAIN  = 2'h3;
  localparam logic [1:0]  DEF_CREEP = 2'h1;
  localparam logic [1:0]  DEF_FMON  = 2'h2;
  localparam logic [1:0]  DEF_FCAL  = 2'h1;
  localparam logic [2:0]  DEF_FLED  = 3'h5;
  localparam logic [21:0] DEF_PLEV  = 22'h06a6d4;
  localparam int DIV_W = 10;
  localparam logic [9:0] STEP_BASE = 10'h200;
  localparam logic [9:0] CAL_BASE  = 10'h040;
  localparam logic [2:0] FLED_MAX  = 3'h6;
  localparam int ACC_W = 26;
  localparam int INC_W = 16;
  localparam logic [7:0] A_CFG0   = 8'h00;
  localparam logic [7:0] A_CFG1   = 8'h04;
  localparam logic [7:0] A_CFG2   = 8'h08;
  localparam logic [7:0] A_CTRL   = 8'h0c;
  localparam logic [7:0] A_PROM0  = 8'h10;
  localparam logic [7:0] A_PROM1  = 8'h14;
  localparam logic [7:0] A_PROM2  = 8'h18;
  localparam logic [7:0] A_STATUS = 8'h1c;
  localparam logic [7:0] A_PCOUNT = 8'h20;
  localparam int CTRL_TEST = 0;
  localparam int CTRL_BURN = 1;

  typedef struct packed {
    logic        prog;
    logic        bank;
    logic [1:0]  gain;
    logic [1:0]  creep;
    logic [1:0]  fmon;
    logic [1:0]  fcal;
    logic [2:0]  fled;
    logic [21:0] plev;
  } mpwc_par_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } mpwc_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } mpwc_apb_rsp_t;
endpackage

// ===== logic/mpwc_decode.sv
`timescale 1ns/100ps
module mpwc_decode (
  input  wire logic [69:0]    word,
  input  wire logic           bank_lock,
  output mpwc_pkg::mpwc_par_t par
);
  logic       bank_choice_bit;
  logic [6:0] ofs;

  always_comb begin
    bank_choice_bit = word[mpwc_pkg::BANK_BIT] | bank_lock;
    ofs = bank_choice_bit ? 7'(mpwc_pkg::BANK1_OFS) : 7'h00;
    // bits 69:68 are never looked at
    par.prog  = word[mpwc_pkg::SEL_BIT];
    par.bank  = bank_choice_bit;
    if (word[mpwc_pkg::SEL_BIT]) begin
      par.gain  = word[mpwc_pkg::GAIN_LSB + ofs +: 2];
      par.creep = word[mpwc_pkg::CREEP_LSB + ofs +: 2];
      par.fmon  = word[mpwc_pkg::FMON_LSB + ofs +: 2];
      par.fcal  = word[mpwc_pkg::FCAL_LSB + ofs +: 2];
      par.fled  = word[mpwc_pkg::FLED_LSB + ofs +: 3];
      par.plev  = word[mpwc_pkg::PLEV_LSB + ofs +: mpwc_pkg::PLEV_W];
    end else begin
      par.gain  = mpwc_pkg::DEF_GAIN;
      par.creep = mpwc_pkg::DEF_CREEP;
      par.fmon  = mpwc_pkg::DEF_FMON;
      par.fcal  = mpwc_pkg::DEF_FCAL;
      par.fled  = mpwc_pkg::DEF_FLED;
      par.plev  = mpwc_pkg::DEF_PLEV;
    end
  end
endmodule // mpwc_decode

// ===== logic/mpwc_rate_div.sv
`timescale 1ns/100ps
module mpwc_rate_div #(
  parameter int W = 10
) (
  input  wire logic         clk,
  input  wire logic         reset,
  input  wire logic         in_pulse,
  input  wire logic [W-1:0] divisor,
  output logic              out_pulse
);
  typedef struct packed {
    logic [W-1:0] cnt;
    logic         out;
  } mpwc_div_st_t;

  mpwc_div_st_t st_q;
  mpwc_div_st_t st_d;

  always_comb begin
    st_d     = st_q;
    st_d.out = 1'b0;
    if (in_pulse) begin
      if (st_q.cnt >= divisor - W'(1)) begin
        st_d.cnt = '0;
        st_d.out = 1'b1;
      end else begin
        st_d.cnt = st_q.cnt + W'(1);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign out_pulse = st_q.out;
endmodule // mpwc_rate_div

// ===== logic/mpwc_top.sv
`timescale 1ns/100ps
module mpwc_top (
  input  wire logic                   CLK,
  input  wire logic                   RESET,
  input  wire mpwc_pkg::mpwc_apb_req_t APB_REQ,
  output mpwc_pkg::mpwc_apb_rsp_t      APB_RSP,
  input  wire logic [15:0]            ENERGY_INC,
  input  wire logic                   ENERGY_VLD,
  output logic                        ENERGY_PULSE,
  output logic [1:0]                  STEPPER_DRIVE_OUTPUTS,
  output logic                        LED_PULSE,
  output logic                        CAL_PULSE
);
  typedef struct packed {
    logic [69:0] shadow;
    logic [69:0] prom;
    logic        use_shadow;
    logic [25:0] acc;
    logic        epulse;
    logic [15:0] pcount;
    logic [31:0] prdata;
    logic        pslverr;
    logic        phase;
    logic [1:0]  drive;
  } mpwc_st_t;

  mpwc_st_t            st_q;
  mpwc_st_t            st_d;
  logic [69:0]         eff_word;
  mpwc_pkg::mpwc_par_t par;
  logic [26:0]         sum_c;
  logic [25:0]         rem_c;
  logic                hit_c;
  logic [9:0]          step_div;
  logic [9:0]          cal_div;
  logic [9:0]          led_div;
  logic                step_pulse;
  logic                wr_en;
  logic                rd_setup;

  ////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic [4:0] gain_factor(input logic [1:0] code);
    case (code)
      2'h0:    gain_factor = 5'h04;
      2'h1:    gain_factor = 5'h10;
      2'h2:    gain_factor = 5'h10;
      default: gain_factor = 5'h14;
    endcase
  endfunction

  function automatic logic [31:0] word_slice(input logic [69:0] w,
                                             input logic [1:0]  idx);
    case (idx)
      2'h0:    word_slice = w[31:0];
      2'h1:    word_slice = w[63:32];
      default: word_slice = {26'h0, w[69:64]};
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // effective word and parameter decode

  always_comb begin
    eff_word = st_q.use_shadow ? st_q.shadow : st_q.prom;
  end

  mpwc_decode u_decode (
    .word      (eff_word),
    .bank_lock (st_q.prom[mpwc_pkg::BANK_BIT]),
    .par       (par)
  );

  // step and lamp rates are 100 * 2**code imp/kWh (lamp code capped at 6), cal 800 * 2**(fmon+fcal); internal pulse base is 51200 imp/kWh
  always_comb begin
    step_div = mpwc_pkg::STEP_BASE >> par.fmon;
    cal_div  = mpwc_pkg::CAL_BASE >> ({1'b0, par.fmon} + {1'b0, par.fcal});
    led_div  = mpwc_pkg::STEP_BASE >> ((par.fled > mpwc_pkg::FLED_MAX) ?
                                       mpwc_pkg::FLED_MAX : par.fled);
  end

  ////////////////////////////////////////////////////////////////////////
  // energy accumulator

  always_comb begin
    sum_c = {1'b0, st_q.acc} + (ENERGY_VLD ? 27'(ENERGY_INC) : 27'h0);
    hit_c = sum_c > 27'(par.plev);
    rem_c = 26'h0;
    if (hit_c) begin
      rem_c = 26'(sum_c - 27'(par.plev));
    end else if (sum_c[26]) begin
      rem_c = 26'h3ffffff;
    end else begin
      rem_c = sum_c[25:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // apb slave and state update

  always_comb begin
    wr_en    = APB_REQ.psel & APB_REQ.penable & APB_REQ.pwrite;
    rd_setup = APB_REQ.psel & ~APB_REQ.penable;
  end

  always_comb begin
    st_d        = st_q;
    st_d.acc    = rem_c;
    st_d.epulse = hit_c;
    st_d.drive  = 2'h0;
    if (hit_c) begin
      st_d.pcount = st_q.pcount + 16'h0001;
    end
    if (step_pulse) begin
      st_d.phase = ~st_q.phase;
      st_d.drive = st_q.phase ? 2'h2 : 2'h1;
    end
    if (rd_setup) begin
      st_d.pslverr = 1'b0;
      case (APB_REQ.paddr)
        mpwc_pkg::A_CFG0:   st_d.prdata = word_slice(st_q.shadow, 2'h0);
        mpwc_pkg::A_CFG1:   st_d.prdata = word_slice(st_q.shadow, 2'h1);
        mpwc_pkg::A_CFG2:   st_d.prdata = word_slice(st_q.shadow, 2'h2);
        mpwc_pkg::A_CTRL:   st_d.prdata = {31'h0, st_q.use_shadow};
        mpwc_pkg::A_PROM0:  st_d.prdata = word_slice(st_q.prom, 2'h0);
        mpwc_pkg::A_PROM1:  st_d.prdata = word_slice(st_q.prom, 2'h1);
        mpwc_pkg::A_PROM2:  st_d.prdata = word_slice(st_q.prom, 2'h2);
        mpwc_pkg::A_STATUS: st_d.prdata = {5'h0, gain_factor(par.gain), par.prog,
                                           par.bank, par.gain, par.creep, par.fmon,
                                           par.fcal, par.fled, 9'h000};
        mpwc_pkg::A_PCOUNT: st_d.prdata = {16'h0, st_q.pcount};
        default: begin
          st_d.prdata  = 32'h0;
          st_d.pslverr = 1'b1;
        end
      endcase
    end
    if (wr_en) begin
      case (APB_REQ.paddr)
        mpwc_pkg::A_CFG0: st_d.shadow[31:0]  = APB_REQ.pwdata;
        mpwc_pkg::A_CFG1: st_d.shadow[63:32] = APB_REQ.pwdata;
        mpwc_pkg::A_CFG2: st_d.shadow[69:64] = APB_REQ.pwdata[5:0];
        mpwc_pkg::A_CTRL: begin
          st_d.use_shadow = APB_REQ.pwdata[mpwc_pkg::CTRL_TEST];
          // burned cells can only go to one
          if (APB_REQ.pwdata[mpwc_pkg::CTRL_BURN]) begin
            st_d.prom = st_q.prom | st_q.shadow;
          end
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pulse rate dividers

  mpwc_rate_div #(.W(mpwc_pkg::DIV_W)) u_step (
    .clk       (CLK),
    .reset     (RESET),
    .in_pulse  (st_q.epulse),
    .divisor   (step_div),
    .out_pulse (step_pulse)
  );

  mpwc_rate_div #(.W(mpwc_pkg::DIV_W)) u_cal (
    .clk       (CLK),
    .reset     (RESET),
    .in_pulse  (st_q.epulse),
    .divisor   (cal_div),
    .out_pulse (CAL_PULSE)
  );

  mpwc_rate_div #(.W(mpwc_pkg::DIV_W)) u_led (
    .clk       (CLK),
    .reset     (RESET),
    .in_pulse  (st_q.epulse),
    .divisor   (led_div),
    .out_pulse (LED_PULSE)
  );

  always_comb begin
    APB_RSP.prdata        = st_q.prdata;
    APB_RSP.pready        = 1'b1;
    APB_RSP.pslverr       = st_q.pslverr;
    ENERGY_PULSE          = st_q.epulse;
    STEPPER_DRIVE_OUTPUTS = st_q.drive;
  end

  ////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RESET);

  sequence s_hit;
    hit_c;
  endsequence

  property p_thr_pulse;
    s_hit |=> ENERGY_PULSE;
  endproperty
  a_thr_pulse: assert property (p_thr_pulse) else $error("missed energy pulse");

  property p_no_pulse;
    !hit_c |=> !ENERGY_PULSE;
  endproperty
  a_no_pulse: assert property (p_no_pulse) else $error("spurious energy pulse");

  property p_remainder;
    s_hit |=> (27'(st_q.acc) + 27'($past(par.plev))) == $past(sum_c);
  endproperty
  a_remainder: assert property (p_remainder) else $error("remainder lost");

  property p_bank_lock;
    st_q.prom[mpwc_pkg::BANK_BIT] |-> par.bank;
  endproperty
  a_bank_lock: assert property (p_bank_lock) else $error("bank zero reselected");

  property p_defaults;
    !eff_word[mpwc_pkg::SEL_BIT] |-> par.plev == mpwc_pkg::DEF_PLEV && par.fled == 3'h5;
  endproperty
  a_defaults: assert property (p_defaults) else $error("defaults not used");

  property p_bank0;
    eff_word[0] && !par.bank |-> par.plev == eff_word[23:2] && par.fled == eff_word[26:24];
  endproperty
  a_bank0: assert property (p_bank0) else $error("bank zero decode wrong");

  property p_bank1;
    eff_word[0] && par.bank |-> par.plev == eff_word[56:35] && par.gain == eff_word[67:66];
  endproperty
  a_bank1: assert property (p_bank1) else $error("bank one decode wrong");

  property p_top_ignored;
    $stable(eff_word[67:0]) && $stable(st_q.prom[mpwc_pkg::BANK_BIT]) |-> $stable(par);
  endproperty
  a_top_ignored: assert property (p_top_ignored) else $error("top bits used");

  property p_cal_rate;
    (13'(cal_div) << (3 + par.fcal)) == 13'(step_div);
  endproperty
  a_cal_rate: assert property (p_cal_rate) else $error("cal divisor wrong");

  property p_led_indep;
    $changed(par.fcal) && $stable(par.fled) |-> $stable(led_div);
  endproperty
  a_led_indep: assert property (p_led_indep) else $error("lamp follows multiplier");
endmodule // mpwc_top

// ===== dv/mpwc_prog_model.sv
`timescale 1ns/100ps
module mpwc_prog_model (
  input  wire mpwc_pkg::mpwc_par_t par,
  input  wire logic [1:0]          spare,
  output logic [69:0]              word
);
  ////////////////////////////////////////////////////////////////
  // prog is cleared only when a test wants an unprogrammed word
  always_comb begin
    word        = '0;
    word[69:68] = spare;
    word[1]     = par.bank;
    word[0]     = par.prog;
    if (par.bank) begin
      word[67:35] = par[32:0];
    end else begin
      word[34:2] = par[32:0];
    end
  end
endmodule // mpwc_prog_model

// ===== dv/mpwc_tb_top.sv
`timescale 1ns/100ps
module mpwc_tb_top;
  logic                    CLK;
  logic                    RESET;
  mpwc_pkg::mpwc_apb_req_t req;
  mpwc_pkg::mpwc_apb_rsp_t rsp;
  logic [15:0]             inc;
  logic                    vld;
  logic                    epulse;
  logic [1:0]              step;
  logic                    led;
  logic                    cal;
  mpwc_pkg::mpwc_par_t     par;
  logic [1:0]              spare;
  logic [69:0]             word;
  logic [31:0]             rd;
  logic                    err;
  logic                    ep;
  int errors, checks_done, seed, cyc, thr, acc, n_ep, n_c, n_l, n_s;
  int nthr, sph;
  int m, f, l;
  logic [1:0] fc[4] = '{2'h2, 2'h0, 2'h1, 2'h3};
  logic [2:0] fl[4] = '{3'h5, 3'h6, 3'h0, 3'h7};

  mpwc_top mpwc_top_inst (.CLK(CLK), .RESET(RESET), .APB_REQ(req), .APB_RSP(rsp),
    .ENERGY_INC(inc), .ENERGY_VLD(vld), .ENERGY_PULSE(epulse),
    .STEPPER_DRIVE_OUTPUTS(step), .LED_PULSE(led), .CAL_PULSE(cal));
  mpwc_prog_model mpwc_prog_model_inst (.par(par), .spare(spare), .word(word));

  initial begin
    CLK = 1'b0;
    forever #2.5 CLK = ~CLK;
  end

  ////////////////////////////////////////////////////////////////
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask

  task report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge CLK);
    req.penable <= 1'b1;
    do @(posedge CLK); while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    err = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    @(posedge CLK);
  endtask

  task automatic rd_chk(string n, logic [7:0] a, logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(n, e, rd);
  endtask

  task automatic cfg_write(logic [31:0] ctrl);
    apb(1'b1, mpwc_pkg::A_CFG0, word[31:0]);
    apb(1'b1, mpwc_pkg::A_CFG1, word[63:32]);
    apb(1'b1, mpwc_pkg::A_CFG2, {26'h0, word[69:64]});
    apb(1'b1, mpwc_pkg::A_CTRL, ctrl);
  endtask

  task do_reset();
    RESET <= 1'b1;
    repeat (2) @(posedge CLK);
    RESET <= 1'b0;
    @(posedge CLK);
  endtask

  function automatic logic [31:0] stat(logic p, logic b, logic [1:0] g, logic [1:0] c,
                                       logic [1:0] mm, logic [1:0] ff, logic [2:0] ll);
    return {5'h0, (g == 2'h0) ? 5'h04 : (g == 2'h3) ? 5'h14 : 5'h10, p, b, g, c, mm, ff, ll,
            9'h0};
  endfunction

  ////////////////////////////////////////////////////////////////
  // reference accumulator, one cycle ahead of the pulse output
  always @(posedge CLK) begin
    cyc++;
    if (cyc > 20000) begin
      errors++;
      report_and_stop();
    end
    if (RESET) begin
      acc = 0; ep = 0; n_ep = 0; n_c = 0; n_l = 0; n_s = 0;
      sph = 0;
      thr = 435924;
    end else begin
      chk("energy_pulse", {31'h0, ep}, {31'h0, epulse});
      n_c += cal;
      n_l += led;
      n_s += (step != 2'h0);
      if (step != 2'h0) begin
        chk("step_phase", (sph != 0) ? 32'h2 : 32'h1, {30'h0, step});
        sph = 1 - sph;
      end
      ep = 1'b0;
      if (vld) begin
        acc += inc;
      end
      // a backlog above the threshold keeps pulsing without new energy
      if (acc > thr) begin
        ep = 1'b1;
        acc -= thr;
        n_ep++;
      end
      // a control write switches the threshold from the next edge on
      if (req.psel && req.penable && req.pwrite && req.paddr == mpwc_pkg::A_CTRL) begin
        thr = nthr;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  initial begin
    seed = 30028; errors = 0; checks_done = 0; cyc = 0; thr = 435924;
    nthr = 435924;
    sph = 0;
    RESET = 1'b1; req = '0; inc = 16'h0; vld = 1'b0; par = '0; spare = 2'h0;
    do_reset();
    repeat (100) begin
      vld <= 1'b1;
      inc <= 16'hff00 | 16'($random(seed));
      @(posedge CLK);
    end
    vld <= 1'b0;
    rd_chk("status_default", mpwc_pkg::A_STATUS, stat(0, 0, 3, 1, 2, 1, 5));
    apb(1'b0, 8'h24, 32'h0);
    chk("unmapped_err", 32'h1, {31'h0, err});
    chk("unmapped_data", 32'h0, rd);
    $display("defaults test done");
    for (int k = 0; k < 4; k++) begin
      do_reset();
      m = k; f = fc[k]; l = fl[k];
      // even configs program bank zero, odd configs bank one
      par <= '{prog: 1'b1, bank: k[0], gain: k[1:0], creep: k[1:0] + 2'h1, fmon: k[1:0],
               fcal: fc[k], fled: fl[k], plev: 22'h00001e + 22'(k)};
      spare <= 2'($random(seed));
      @(posedge CLK);
      nthr = 30 + k;
      cfg_write(32'h1);
      rd_chk("cfg0", mpwc_pkg::A_CFG0, word[31:0]);
      rd_chk("status", mpwc_pkg::A_STATUS, stat(1, k[0], k, k + 1, m, f, l));
      repeat (1200) begin
        vld <= 1'b1;
        inc <= 16'($random(seed)) & 16'h003f;
        @(posedge CLK);
      end
      vld <= 1'b0;
      // let the accumulator backlog drain before counting
      repeat (300) @(posedge CLK);
      chk("cal_pulses", n_ep / (64 >> (m + f)), n_c);
      chk("step_pulses", n_ep / (512 >> m), n_s);
      chk("led_pulses", n_ep / (512 >> ((l > 6) ? 6 : l)), n_l);
      rd_chk("pcount", mpwc_pkg::A_PCOUNT, n_ep);
      $display("config %0d test done", k);
    end
    cfg_write(32'h2);
    rd_chk("prom0", mpwc_pkg::A_PROM0, word[31:0]);
    rd_chk("prom2", mpwc_pkg::A_PROM2, {26'h0, word[69:64]});
    rd_chk("status_prom", mpwc_pkg::A_STATUS, stat(1, 1, 3, 0, 3, 3, 7));
    par.bank <= 1'b0;
    // bank one holds zeros here, so the locked threshold is zero
    nthr = 0;
    @(posedge CLK);
    cfg_write(32'h1);
    rd_chk("status_lock", mpwc_pkg::A_STATUS, stat(1, 1, 0, 0, 0, 0, 0));
    $display("bank lock test done");
    report_and_stop();
  end
endmodule // mpwc_tb_top
